// ===== gpt_timer.sv
// General-purpose timer: prescaler, auto-reload counter, channels.
// Assumes config inputs are static-ish levels from the ref_clk domain;
// pin inputs are asynchronous and are double-synchronised here.
`timescale 1ns/1ps
module gpt_timer
  import gpt_pkg::*;
#(
  parameter int CNT_W = 16, // Counter width, 32 for wide instance
  parameter int NUM_CH = 4, // Channel count
  parameter bit UP_ONLY = 1'b0, // Force upward counting
  parameter bit FULL = 1'b1 // Encoder, hall and DMA present
)(
  input wire logic ref_clk, // Timer kernel clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic cnt_en, // Counter enable level
  input wire logic [1:0] dir_mode, // Up, down or center
  input wire logic opm_stop, // Stop counter at update
  input wire logic [CNT_W-1:0] reload, // Auto-reload value
  input wire logic [GPT_PSC_W-1:0] presc, // Divide by presc+1
  input wire logic slow_clk_sel, // Count slow crystal edges
  input wire logic slow_clk_pin, // Slow crystal clock pin
  input wire logic dbg_halt, // Processor halted in debug
  input wire logic dbg_freeze, // Freeze while halted
  input wire logic enc_mode, // Quadrature encoder counting
  input wire logic enc_a, // Encoder phase A pin
  input wire logic enc_b, // Encoder phase B pin
  input wire logic hall_mode, // Hall sensor interface on
  input wire logic [GPT_HALL_N-1:0] hall_in, // Hall sensor pins
  input wire logic [1:0] trig_mode, // Trigger input usage
  input wire logic trig_in, // Trigger from another timer
  input wire logic dma_en, // DMA request enable
  input wire logic [2*NUM_CH-1:0] ch_mode, // Per-channel function
  input wire logic [CNT_W*NUM_CH-1:0] ch_cmp, // Per-channel compare
  input wire logic [NUM_CH-1:0] ch_both_edge, // Capture both edges
  input wire logic [NUM_CH-1:0] ch_in, // Capture input pins
  output logic [CNT_W-1:0] count_ff, // Counter value
  output logic dir_down_ff, // Counting downward
  output logic upd_ff, // Update event pulse
  output logic trig_out_ff, // Trigger to other timers
  output logic dma_req_ff, // DMA request pulse
  output logic [NUM_CH-1:0] ch_out, // Channel output levels
  output logic [CNT_W*NUM_CH-1:0] cap_val, // Captured values
  output logic [NUM_CH-1:0] cap_evt // Capture event pulses
);
  // Bit positions inside the synchroniser vector
  localparam int PIN_W = GPT_PIN_FIXED + NUM_CH;
  localparam int IDX_HALL = NUM_CH;
  localparam int IDX_B = NUM_CH + 3;
  localparam int IDX_A = NUM_CH + 4;
  localparam int IDX_SLOW = NUM_CH + 5;

  logic [PIN_W-1:0] pin_raw; // Raw pin inputs
  logic [PIN_W-1:0] s1_ff; // First sync stage
  logic [PIN_W-1:0] s2_ff; // Second sync stage
  logic [PIN_W-1:0] s3_ff; // Edge history stage
  logic [GPT_PSC_W-1:0] psc_ff; // Prescaler count
  gpt_cnt_state_t st_ff; // Run state
  gpt_cnt_state_t nxt_st; // Next run state
  logic [CNT_W-1:0] nxt_count; // Next counter value
  logic upd_nxt; // Update in this cycle
  logic trig_d_ff; // Previous trigger level
  logic start_ff; // Started by trigger
  logic opm_done_ff; // Stopped after one pulse
  logic [NUM_CH-1:0] match_evt; // Channel match pulses

  logic slow_rise; // Slow clock rising edge
  logic enc_step; // One encoder phase moved
  logic enc_up; // Encoder moving forward
  logic hall_chg; // A hall sensor toggled
  logic trig_rise; // Trigger rising edge
  logic frozen; // Debug freeze active
  logic gate_ok; // Trigger gate open
  logic go; // Counter should run
  logic step_en; // Counting allowed
  logic src_ok; // Prescaler input event
  logic tick; // Prescaled count event
  logic cnt_rst; // Trigger or hall restart
  logic [1:0] eff_dir; // Direction after variant
  logic center; // Center-aligned counting

  assign pin_raw = {slow_clk_pin, enc_a, enc_b, hall_in, ch_in};

  // Two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Pin edges, all taken after the second stage
  assign slow_rise = s2_ff[IDX_SLOW] & ~s3_ff[IDX_SLOW];
  assign enc_step = (s2_ff[IDX_A] ^ s3_ff[IDX_A])
                  ^ (s2_ff[IDX_B] ^ s3_ff[IDX_B]);
  assign enc_up = s2_ff[IDX_A] ^ s3_ff[IDX_B];
  // Sensors change one at a time, so parity flips per change
  assign hall_chg = (^s2_ff[IDX_HALL +: GPT_HALL_N])
                  ^ (^s3_ff[IDX_HALL +: GPT_HALL_N]);

  // Trigger comes from a sibling timer on this clock: no sync
  always_ff @(posedge ref_clk) begin
    if (!nrst) trig_d_ff <= 1'b0;
    else trig_d_ff <= trig_in;
  end
  assign trig_rise = trig_in & ~trig_d_ff;

  assign frozen = dbg_halt & dbg_freeze;
  assign gate_ok = (trig_mode != GPT_TRG_GATE) | trig_in;
  assign go = (cnt_en | start_ff) & ~opm_done_ff;
  assign step_en = (st_ff != GPT_ST_IDLE) & go & ~frozen & gate_ok;
  // Timers of every variant may count slow crystal edges instead
  assign src_ok = slow_clk_sel ? slow_rise : 1'b1;
  assign tick = step_en & src_ok & (psc_ff == presc);
  assign cnt_rst = ~frozen & (((trig_mode == GPT_TRG_RESET) & trig_rise)
                 | (FULL & hall_mode & hall_chg));
  // Up-only variants ignore the direction select
  assign eff_dir = UP_ONLY ? GPT_DIR_UP : dir_mode;
  assign center = (eff_dir == GPT_DIR_CENTER);

  // Prescaler: divides by presc+1, restarted with the counter
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      psc_ff <= GPT_PSC_RST;
    end else if (cnt_rst) begin
      psc_ff <= GPT_PSC_RST;
    end else if (step_en && src_ok) begin
      if (psc_ff == presc) psc_ff <= GPT_PSC_RST;
      else psc_ff <= psc_ff + 1'b1;
    end
  end

  // Trigger start; an update in one-pulse use wins over a start
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      start_ff <= 1'b0;
    end else if (upd_nxt && opm_stop) begin
      start_ff <= 1'b0;
    end else if (trig_mode == GPT_TRG_START && trig_rise) begin
      start_ff <= 1'b1;
    end
  end

  // One-pulse stop latch, released by enable drop or new start
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      opm_done_ff <= 1'b0;
    end else if (upd_nxt && opm_stop) begin
      opm_done_ff <= 1'b1;
    end else if (!cnt_en || (trig_mode == GPT_TRG_START && trig_rise)) begin
      opm_done_ff <= 1'b0;
    end
  end

  // Next counter value; restart beats encoder beats tick
  always_comb begin
    nxt_count = count_ff;
    upd_nxt = 1'b0;
    if (cnt_rst) begin
      nxt_count = (st_ff == GPT_ST_DOWN) ? reload : '0;
      upd_nxt = 1'b1;
    end else if (FULL && enc_mode) begin
      // Counter follows the encoder, x4 decoding
      if (enc_step && step_en) begin
        if (enc_up) begin
          if (count_ff >= reload) begin
            nxt_count = '0;
            upd_nxt = 1'b1;
          end else begin
            nxt_count = count_ff + 1'b1;
          end
        end else if (count_ff == '0) begin
          nxt_count = reload;
          upd_nxt = 1'b1;
        end else begin
          nxt_count = count_ff - 1'b1;
        end
      end
    end else if (tick) begin
      case (st_ff)
        GPT_ST_UP: begin
          if (count_ff >= reload) begin
            // Center mode turns round instead of wrapping
            if (center && reload != '0) nxt_count = count_ff - 1'b1;
            else nxt_count = '0;
            upd_nxt = 1'b1;
          end else begin
            nxt_count = count_ff + 1'b1;
          end
        end
        GPT_ST_DOWN: begin
          if (count_ff == '0) begin
            if (center) nxt_count = {{(CNT_W-1){1'b0}}, 1'b1};
            else nxt_count = reload;
            upd_nxt = 1'b1;
          end else begin
            nxt_count = count_ff - 1'b1;
          end
        end
        default: begin
          nxt_count = count_ff;
        end
      endcase
    end
  end

  // Run state and direction
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      GPT_ST_IDLE: begin
        if (go) nxt_st = (eff_dir == GPT_DIR_DOWN) ? GPT_ST_DOWN
                                                   : GPT_ST_UP;
      end
      GPT_ST_UP: begin
        if (!go) nxt_st = GPT_ST_IDLE;
        else if (eff_dir == GPT_DIR_DOWN) nxt_st = GPT_ST_DOWN;
        else if (center && tick && !cnt_rst && !enc_mode
                 && count_ff >= reload && reload != '0)
          nxt_st = GPT_ST_DOWN;
      end
      GPT_ST_DOWN: begin
        if (!go) nxt_st = GPT_ST_IDLE;
        else if (eff_dir == GPT_DIR_UP) nxt_st = GPT_ST_UP;
        else if (center && tick && !cnt_rst && !enc_mode
                 && count_ff == '0)
          nxt_st = GPT_ST_UP;
      end
      default: nxt_st = GPT_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_ff <= GPT_ST_IDLE;
      dir_down_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      dir_down_ff <= (nxt_st == GPT_ST_DOWN);
    end
  end

  // Counter, update pulse and trigger output share one edge
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count_ff <= '0;
      upd_ff <= 1'b0;
      trig_out_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      upd_ff <= upd_nxt;
      trig_out_ff <= upd_nxt;
    end
  end

  // DMA request per timer: update, capture or match
  always_ff @(posedge ref_clk) begin
    if (!nrst) dma_req_ff <= 1'b0;
    else dma_req_ff <= FULL & dma_en
                     & (upd_ff | (|cap_evt) | (|match_evt));
  end

  // Channels; NUM_CH sets four, two or one per variant
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    gpt_ch_if #(.CNT_W(CNT_W)) bus ();
    logic hall_ch; // Channel 0 takes hall parity
    assign hall_ch = FULL && hall_mode && (k == 0);
    assign bus.cnt = count_ff;
    assign bus.upd = upd_ff;
    assign bus.cap_lvl = hall_ch ? (^s2_ff[IDX_HALL +: GPT_HALL_N])
                                 : s2_ff[k];
    gpt_channel #(.CNT_W(CNT_W)) u_ch (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .mode(ch_mode[2*k +: 2]),
      .cmp_val(ch_cmp[CNT_W*k +: CNT_W]),
      .both_edge(ch_both_edge[k] | hall_ch),
      .bus(bus.chan)
    );
    assign ch_out[k] = bus.pin_out;
    assign cap_val[CNT_W*k +: CNT_W] = bus.cap_val;
    assign cap_evt[k] = bus.cap_evt;
    assign match_evt[k] = bus.match_evt;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_freeze;
    frozen |=> $stable(count_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("counter moved while frozen");

  property p_up_wrap;
    (tick && !cnt_rst && !enc_mode && st_ff == GPT_ST_UP
     && eff_dir == GPT_DIR_UP && count_ff >= reload)
      |=> (count_ff == '0 && upd_ff);
  endproperty
  a_up_wrap: assert property (p_up_wrap)
    else $error("no wrap to zero at reload");

  property p_down_reload;
    (tick && !cnt_rst && !enc_mode && st_ff == GPT_ST_DOWN
     && eff_dir == GPT_DIR_DOWN && count_ff == '0)
      |=> (count_ff == $past(reload) && upd_ff);
  endproperty
  a_down_reload: assert property (p_down_reload)
    else $error("no reload after zero");

  sequence s_div2_start;
    tick && presc == 16'h0001 && !slow_clk_sel && !cnt_rst;
  endsequence
  property p_presc;
    s_div2_start ##1 (step_en && presc == 16'h0001 && !cnt_rst)[*2]
      |-> tick;
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler period wrong");

  property p_dma;
    (upd_ff && dma_en && FULL) |=> dma_req_ff;
  endproperty
  a_dma: assert property (p_dma)
    else $error("update gave no DMA request");

  property p_enc;
    (FULL && enc_mode && enc_step && enc_up && step_en && !cnt_rst
     && count_ff < reload) |=> count_ff == $past(count_ff) + 1'b1;
  endproperty
  a_enc: assert property (p_enc)
    else $error("encoder step not counted");

  property p_up_only;
    UP_ONLY |-> !dir_down_ff;
  endproperty
  a_up_only: assert property (p_up_only)
    else $error("up-only timer counted down");

  property p_trig_rst;
    (trig_mode == GPT_TRG_RESET && trig_rise && !frozen
     && st_ff == GPT_ST_UP) |=> (count_ff == '0 && trig_out_ff);
  endproperty
  a_trig_rst: assert property (p_trig_rst)
    else $error("trigger reset ignored");

  property p_hall;
    (FULL && hall_mode && hall_chg && ch_mode[1:0] == GPT_CH_CAPTURE)
      |=> cap_evt[0];
  endproperty
  a_hall: assert property (p_hall)
    else $error("hall change not captured");

  property p_slow;
    (slow_clk_sel && !slow_rise) |-> !tick;
  endproperty
  a_slow: assert property (p_slow)
    else $error("tick without slow clock edge");
endmodule : gpt_timer

// ===== gpt_pkg.sv
// Shared constants for the general-purpose timer and its channels.
// Assumes a single ref_clk domain; no software register map exists.
package gpt_pkg;
  // Counter direction select
  localparam logic [1:0] GPT_DIR_UP = 2'h0;
  localparam logic [1:0] GPT_DIR_DOWN = 2'h1;
  localparam logic [1:0] GPT_DIR_CENTER = 2'h2;
  // Channel function select
  localparam logic [1:0] GPT_CH_CAPTURE = 2'h0;
  localparam logic [1:0] GPT_CH_COMPARE = 2'h1;
  localparam logic [1:0] GPT_CH_PWM = 2'h2;
  localparam logic [1:0] GPT_CH_ONEPULSE = 2'h3;
  // Inter-timer trigger input usage
  localparam logic [1:0] GPT_TRG_NONE = 2'h0;
  localparam logic [1:0] GPT_TRG_RESET = 2'h1;
  localparam logic [1:0] GPT_TRG_GATE = 2'h2;
  localparam logic [1:0] GPT_TRG_START = 2'h3;
  // Reset values and fixed widths
  localparam int GPT_PSC_W = 16;
  localparam logic [15:0] GPT_PSC_RST = 16'h0000;
  localparam int GPT_HALL_N = 3;
  localparam int GPT_PIN_FIXED = 6;
  // Slow crystal clock nominal rate, Hz
  localparam int GPT_SLOW_CLK_HZ = 32768;
  // Counter run state, one-hot
  typedef enum logic [2:0] {
    GPT_ST_IDLE = 3'b001,
    GPT_ST_UP = 3'b010,
    GPT_ST_DOWN = 3'b100
  } gpt_cnt_state_t;
endpackage : gpt_pkg

// ===== gpt_ch_if.sv
// Bundle between the timer core and one capture/compare channel.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ps
interface gpt_ch_if #(parameter int CNT_W = 16);
  logic [CNT_W-1:0] cnt; // Current counter value
  logic upd; // Update event pulse
  logic cap_lvl; // Synchronised capture input level
  logic [CNT_W-1:0] cap_val; // Last captured count
  logic cap_evt; // Capture event pulse
  logic match_evt; // Compare match pulse
  logic pin_out; // Channel output level
  modport ctl (output cnt, upd, cap_lvl,
    input cap_val, cap_evt, match_evt, pin_out);
  modport chan (input cnt, upd, cap_lvl,
    output cap_val, cap_evt, match_evt, pin_out);
endinterface : gpt_ch_if

// ===== gpt_channel.sv
// One capture/compare channel: capture, compare toggle, PWM, one-pulse.
// Assumes cap_lvl already synchronised and cnt/upd from the timer core.
`timescale 1ns/1ps
module gpt_channel
  import gpt_pkg::*;
#(
  parameter int CNT_W = 16 // Counter width
)(
  input wire logic ref_clk, // Timer kernel clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [1:0] mode, // Channel function
  input wire logic [CNT_W-1:0] cmp_val, // Compare / duty value
  input wire logic both_edge, // Capture on both edges
  gpt_ch_if.chan bus // Link to timer core
);
  logic lvl_d_ff; // Previous capture level
  logic [CNT_W-1:0] cnt_d_ff; // Previous count, for match edge
  logic [CNT_W-1:0] cap_ff; // Captured value
  logic cap_evt_ff; // Capture pulse
  logic match_ff; // Match pulse
  logic out_ff; // Output level
  logic armed_ff; // One-pulse armed
  logic cap_edge; // Active capture edge
  logic hit; // Counter just arrived at cmp_val

  assign cap_edge = both_edge ? (bus.cap_lvl ^ lvl_d_ff)
                              : (bus.cap_lvl & ~lvl_d_ff);
  // Only a fresh arrival matches, so a frozen counter fires once
  assign hit = (bus.cnt == cmp_val) && (bus.cnt != cnt_d_ff);

  assign bus.cap_val = cap_ff;
  assign bus.cap_evt = cap_evt_ff;
  assign bus.match_evt = match_ff;
  assign bus.pin_out = out_ff;

  // History for edge and match detection
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lvl_d_ff <= 1'b0;
      cnt_d_ff <= '0;
    end else begin
      lvl_d_ff <= bus.cap_lvl;
      cnt_d_ff <= bus.cnt;
    end
  end

  // Input capture of the live count
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cap_ff <= '0;
      cap_evt_ff <= 1'b0;
    end else if (mode == GPT_CH_CAPTURE && cap_edge) begin
      cap_ff <= bus.cnt;
      cap_evt_ff <= 1'b1;
    end else begin
      cap_evt_ff <= 1'b0;
    end
  end

  // Output waveform per function
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      out_ff <= 1'b0;
      match_ff <= 1'b0;
      armed_ff <= 1'b1;
    end else begin
      match_ff <= hit && (mode != GPT_CH_CAPTURE);
      case (mode)
        GPT_CH_COMPARE: begin
          if (hit) out_ff <= ~out_ff;
          armed_ff <= 1'b1;
        end
        GPT_CH_PWM: begin
          out_ff <= (bus.cnt < cmp_val);
          armed_ff <= 1'b1;
        end
        GPT_CH_ONEPULSE: begin
          // Single pulse from match to next update, then disarmed
          if (bus.upd) begin
            out_ff <= 1'b0;
            armed_ff <= armed_ff & ~out_ff;
          end else if (hit && armed_ff) begin
            out_ff <= 1'b1;
          end
        end
        default: begin
          out_ff <= 1'b0;
          armed_ff <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_ch_capture;
    (mode == GPT_CH_CAPTURE && cap_edge)
      |=> (cap_evt_ff && cap_ff == $past(bus.cnt));
  endproperty
  a_ch_capture: assert property (p_ch_capture)
    else $error("capture did not latch count");

  sequence s_opm_fire;
    mode == GPT_CH_ONEPULSE && armed_ff && hit && !bus.upd;
  endsequence
  property p_ch_onepulse;
    s_opm_fire ##1 (mode == GPT_CH_ONEPULSE && !bus.upd) |-> out_ff;
  endproperty
  a_ch_onepulse: assert property (p_ch_onepulse)
    else $error("one-pulse output not held");
endmodule : gpt_channel

// ===== gpt_pin_model.sv
// Pin-side partner: quadrature encoder, hall sensors, capture pins.
// Assumes clk is the timer clock; pins move just after falling edges.
`timescale 1ns/1ps
module gpt_pin_model
  import gpt_pkg::*;
(
  input wire logic clk, // Timer clock
  output logic enc_a, // Encoder phase A
  output logic enc_b, // Encoder phase B
  output logic [GPT_HALL_N-1:0] hall_in, // Hall sensor outputs
  output logic [3:0] ch_in // Capture pins
);
  logic [1:0] ph = 2'h0; // Gray phase index
  // Idle levels at time zero
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    hall_in = 3'h0;
    ch_in = 4'h0;
  end
  // One edge; A leads when fwd; wait lets the synchroniser settle
  task automatic enc_step(input logic fwd);
    @(negedge clk);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    enc_a = ph[1] ^ ph[0];
    enc_b = ph[1];
    repeat (4) @(negedge clk);
  endtask : enc_step
  // New sensor code, one to three sensors
  task automatic hall_set(input logic [2:0] v);
    @(negedge clk);
    hall_in = v;
  endtask : hall_set
  // Capture pin level
  task automatic cap_set(input int ch, input logic v);
    @(negedge clk);
    ch_in[ch] = v;
  endtask : cap_set
endmodule : gpt_pin_model

// ===== tb_top.sv
// Self-checking bench for the 16-bit four-channel timer.
// Assumes gpt_pkg, gpt_timer and gpt_pin_model are compiled first.
`timescale 1ns/1ps
module tb_top;
  import gpt_pkg::*;
  logic ref_clk = 1'b0; // 40 MHz clock
  logic nrst = 1'b0; // Reset, active low
  logic cnt_en, opm_stop, slow_sel, slow_pin, dbg_halt, dbg_frz;
  logic enc_mode, hall_mode, trig_in, dma_en, enc_a, enc_b;
  logic dir_down_ff, upd_ff, trig_out_ff, dma_req_ff;
  logic [1:0] dir_mode, trig_mode;
  logic [15:0] reload, presc, count_ff;
  logic [7:0] ch_mode;
  logic [63:0] ch_cmp, cap_val;
  logic [2:0] hall_in;
  logic [3:0] ch_in, ch_out, cap_evt, both_e;
  int n_mismatch = 0;
  int num_checks = 0;
  // Free-running clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  gpt_timer i_dut (.ref_clk(ref_clk), .nrst(nrst), .cnt_en(cnt_en),
    .dir_mode(dir_mode), .opm_stop(opm_stop), .reload(reload),
    .presc(presc), .slow_clk_sel(slow_sel), .slow_clk_pin(slow_pin),
    .dbg_halt(dbg_halt), .dbg_freeze(dbg_frz), .enc_mode(enc_mode),
    .enc_a(enc_a), .enc_b(enc_b), .hall_mode(hall_mode),
    .hall_in(hall_in), .trig_mode(trig_mode), .trig_in(trig_in),
    .dma_en(dma_en), .ch_mode(ch_mode), .ch_cmp(ch_cmp),
    .ch_both_edge(both_e), .ch_in(ch_in), .count_ff(count_ff),
    .dir_down_ff(dir_down_ff), .upd_ff(upd_ff),
    .trig_out_ff(trig_out_ff), .dma_req_ff(dma_req_ff),
    .ch_out(ch_out), .cap_val(cap_val), .cap_evt(cap_evt));
  gpt_pin_model i_pin (.clk(ref_clk), .enc_a(enc_a), .enc_b(enc_b),
    .hall_in(hall_in), .ch_in(ch_in));
  // Count and report one comparison
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // Quiet configuration; slow clock source stays unused
  task automatic cfg_idle;
    {cnt_en, opm_stop, slow_sel, slow_pin, dbg_halt, dbg_frz} = 6'h00;
    {enc_mode, hall_mode, trig_in, dma_en} = 4'h0;
    dir_mode = GPT_DIR_UP;
    trig_mode = GPT_TRG_NONE;
    reload = 16'h00ff;
    presc = 16'h0000;
    ch_mode = 8'h00;
    both_e = 4'h0;
    ch_cmp = 64'h0000_0000_0000_0000;
  endtask : cfg_idle
  // Idle config, then five-cycle reset
  task automatic do_reset;
    @(negedge ref_clk);
    cfg_idle();
    nrst = 1'b0;
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
  endtask : do_reset
  // Track value, tick spacing, update and DMA over n count changes
  task automatic count_seq(input logic [1:0] dm,
      input logic [15:0] ps, input logic [15:0] rl, input int n);
    logic [15:0] prev, exp;
    logic wrap, pend, dn;
    int gap, nchg;
    do_reset();
    dir_mode = dm;
    presc = ps;
    reload = rl;
    dma_en = 1'b1;
    cnt_en = 1'b1;
    prev = 16'h0000;
    dn = (dm == GPT_DIR_DOWN);
    {gap, nchg, pend} = '0;
    repeat (n * (ps + 1) + 20) begin
      @(negedge ref_clk);
      gap++;
      if (pend) chk(dma_req_ff === 1'b1, "no dma request");
      pend = 1'b0;
      if (count_ff !== prev) begin
        wrap = dn ? prev == 16'h0000 : prev == rl;
        if (!dn) exp = wrap ? 16'h0000 : prev + 16'h0001;
        else exp = wrap ? rl : prev - 16'h0001;
        // Center mode reaches the limit, then turns round one step back
        if (wrap && dm == GPT_DIR_CENTER) begin
          exp = dn ? 16'h0001 : rl - 16'h0001;
          dn = !dn;
        end
        chk(dir_down_ff === dn, "direction flag");
        chk(count_ff === exp, "count value");
        chk(upd_ff === wrap, "update pulse");
        chk(trig_out_ff === wrap, "trigger out");
        if (nchg > 0) chk(gap == ps + 1, "tick spacing");
        {pend, prev, gap} = {wrap, count_ff, 32'd0};
        nchg++;
      end
    end
    chk(nchg >= n, "too few ticks");
  endtask : count_seq
  // Freeze only when both halt and freeze option are set
  task automatic freeze_chk;
    logic [15:0] v;
    do_reset();
    cnt_en = 1'b1;
    dbg_halt = 1'b1;
    repeat (4) @(negedge ref_clk);
    v = count_ff;
    repeat (3) @(negedge ref_clk);
    chk(count_ff !== v, "halt alone froze");
    dbg_frz = 1'b1;
    v = count_ff;
    repeat (8) @(negedge ref_clk);
    chk(count_ff === v, "not frozen");
  endtask : freeze_chk
  // x4 decode both ways, reload on passing zero
  task automatic enc_chk;
    do_reset();
    enc_mode = 1'b1;
    cnt_en = 1'b1;
    repeat (8) i_pin.enc_step(1'b1);
    chk(count_ff === 16'h0008, "encoder up");
    repeat (11) i_pin.enc_step(1'b0);
    chk(count_ff === 16'h00fd, "encoder down");
  endtask : enc_chk
  // All four channel functions at once, then a held capture
  task automatic chan_chk;
    logic [15:0] pc;
    logic po, os;
    int tg, ne;
    do_reset();
    ch_mode = {GPT_CH_ONEPULSE, GPT_CH_PWM, GPT_CH_CAPTURE, GPT_CH_COMPARE};
    ch_cmp = {4{16'h0003}};
    reload = 16'h0007;
    cnt_en = 1'b1;
    {pc, po, os, tg, ne} = '0;
    repeat (32) begin
      @(negedge ref_clk);
      chk(ch_out[2] === (pc < 16'h0003), "pwm level");
      if (ch_out[0] !== po) tg++;
      if (ch_out[3] === 1'b1) os = 1'b1;
      {pc, po} = {count_ff, ch_out[0]};
    end
    chk(tg >= 3 && tg <= 4, "compare toggles");
    chk(os && ch_out[3] === 1'b0, "one pulse");
    cnt_en = 1'b0;
    repeat (3) @(negedge ref_clk);
    i_pin.cap_set(1, 1'b1);
    repeat (8) begin
      @(negedge ref_clk);
      if (cap_evt[1] === 1'b1) ne++;
    end
    chk(ne == 1, "capture pulse");
    chk(cap_val[31:16] === count_ff, "capture value");
    // Falling edge captures only once both-edge use is chosen
    ne = 0;
    both_e = 4'h2;
    i_pin.cap_set(1, 1'b0);
    repeat (8) begin
      @(negedge ref_clk);
      if (cap_evt[1] === 1'b1) ne++;
    end
    chk(ne == 1, "both-edge capture");
  endtask : chan_chk
  // Hall change captures on channel 0 and restarts the count
  task automatic hall_chk;
    int ne, nu;
    do_reset();
    hall_mode = 1'b1;
    cnt_en = 1'b1;
    {ne, nu} = '0;
    repeat (20) @(negedge ref_clk);
    i_pin.hall_set(3'h4); // One sensor moves, so parity flips
    repeat (8) begin
      @(negedge ref_clk);
      if (cap_evt[0] === 1'b1) ne++;
      if (upd_ff === 1'b1) nu++;
    end
    chk(ne == 1 && nu == 1, "hall events");
    chk(count_ff < 16'h0008, "hall restart");
  endtask : hall_chk
  // Reset, gate and start usage of the trigger link
  task automatic trig_chk;
    do_reset();
    trig_mode = GPT_TRG_RESET;
    cnt_en = 1'b1;
    repeat (20) @(negedge ref_clk);
    trig_in = 1'b1;
    @(negedge ref_clk);
    chk(count_ff === 16'h0000 && upd_ff === 1'b1, "trig reset");
    trig_mode = GPT_TRG_GATE;
    trig_in = 1'b0;
    repeat (3) @(negedge ref_clk);
    pc_hold();
    do_reset();
    trig_mode = GPT_TRG_START;
    opm_stop = 1'b1;
    reload = 16'h0004;
    repeat (3) @(negedge ref_clk);
    chk(count_ff === 16'h0000, "ran before start");
    trig_in = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk(count_ff !== 16'h0000, "trig start");
    repeat (10) @(negedge ref_clk);
    chk(count_ff === 16'h0000, "one-pulse stop");
  endtask : trig_chk
  // Closed gate holds the count
  task automatic pc_hold;
    logic [15:0] v;
    v = count_ff;
    repeat (6) @(negedge ref_clk);
    chk(count_ff === v, "gate closed");
  endtask : pc_hold
  // Slow crystal edges, not ref_clk cycles, clock the prescaler
  task automatic slow_chk;
    do_reset();
    slow_sel = 1'b1;
    cnt_en = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk(count_ff === 16'h0000, "ran without slow edge");
    repeat (5) begin
      slow_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      slow_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
    chk(count_ff === 16'h0005, "slow edge count");
  endtask : slow_chk
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    cfg_idle();
    count_seq(GPT_DIR_UP, 16'h0000, 16'h0002, 12);
    count_seq(GPT_DIR_UP, 16'h0002, 16'h0005, 14);
    count_seq(GPT_DIR_DOWN, 16'h0001, 16'h0003, 12);
    count_seq(GPT_DIR_CENTER, 16'h0000, 16'h0003, 14);
    freeze_chk();
    enc_chk();
    chan_chk();
    hall_chk();
    trig_chk();
    slow_chk();
    complete_run();
  end
  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    #(25 * 8000);
    n_mismatch++;
    complete_run();
  end
endmodule : tb_top
